// [logic/ast_pkg.sv]
package ast_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RES_W = 10;
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam int PIN_W = RES_W * NUM_CH;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CLK_GATE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PORT2 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CHAN = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;

	// converter_mode_reg fields
	localparam int MODE_START_BIT = 7;
	localparam int MODE_CHSEL_BIT = 6;
	localparam int MODE_FR_LSB = 3;
	localparam int MODE_FR_W = 3;
	localparam logic [7:0] MODE_RST = 8'h00;

	// port2 register fields
	localparam int PORT2_DIR_BIT = 0;
	localparam int PORT2_OUT_BIT = 1;
	localparam logic PORT2_DIR_RST = 1'h1;

	localparam int IRQ_CONV_END_BIT = 0;
	localparam logic [CH_W-1:0] CHAN_RST = 2'h0;

	// left alignment of the result inside a 16-bit word
	localparam int RESULT_LSB = 6;
	localparam logic [RESULT_LSB-1:0] RESULT_PAD = 6'h00;

	// conversion length and sampling length, in conversion clocks
	localparam logic [4:0] CONV_FAD = 5'h13;
	localparam logic [4:0] SAMPLE_FAD = 5'h07;

	// conversion clock divider reload (ratio minus one) per speed code
	localparam logic [5:0] DIV_M1 [8] = '{6'h3F, 6'h1F, 6'h0F, 6'h07,
		6'h05, 6'h04, 6'h03, 6'h01};

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		AST_IDLE = 1'b0,
		AST_CONVERT = 1'b1
	} ast_fsm_e;

	typedef struct packed {
		logic [PIN_W-1:0]  sync1;
		logic [PIN_W-1:0]  sync2;
		logic [7:0]        mode;
		logic              clk_gate;
		logic              port_dir;
		logic              port_out;
		logic [CH_W-1:0]   chan;
		logic              irq_stat;
		logic              irq_mask;
		logic              irq;
		logic [15:0]       result;
		logic [CH_W-1:0]   last_ch;
		logic [CH_W-1:0]   cur_ch;
		logic [RES_W-1:0]  held;
		ast_fsm_e          fsm;
		logic [5:0]        div_cnt;
		logic              fad_tick;
		logic [4:0]        fad_cnt;
		logic              aw_have;
		logic [ADDR_W-1:0] awaddr;
		logic              w_have;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} ast_state_s;

endpackage

// [logic/ast_ctrl.sv]
`timescale 1ns/10ps

// Summary of operation
// - Writing one to the start bit of the mode register begins a conversion once the clock-enable bit is also one.
// - At the end of a conversion the value goes to the result register and the end interrupt is raised in the same cycle.
// - Conversions start only from the software start bit, with no hardware trigger.
// - In select mode only the one chosen channel is converted.
// - In sequential mode conversions repeat while the start bit stays set, each raising the interrupt.
// - A dedicated conversion-end interrupt tells software that a new result is ready.
// - Channel zero, shared with port 2 bit 0, supplies the analog input when chosen.
// - The channel selection mode bit picks select mode at zero and scan mode at one.
// - The converter clock runs only while its clock-enable bit is one and stops at zero.
module ast_ctrl
	import ast_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output      logic              s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output      logic              s_axi_wready,
	output      logic [1:0]        s_axi_bresp,
	output      logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output      logic              s_axi_arready,
	output      logic [DATA_W-1:0] s_axi_rdata,
	output      logic [1:0]        s_axi_rresp,
	output      logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [RES_W-1:0]  analog_input_ch0,
	input  wire logic [RES_W-1:0]  analog_input_ch1,
	input  wire logic [RES_W-1:0]  analog_input_ch2,
	input  wire logic [RES_W-1:0]  analog_input_ch3,
	output      logic              port2_bit0_out,
	output      logic              port2_bit0_oe_n,
	output      logic              conversion_end_irq
);

	ast_state_s s_ff;
	ast_state_s nxt_s;

	logic                conv_done;
	logic                wr_fire;
	logic                wr_lo;
	logic [DATA_W-1:0]   rd_val;
	logic [1:0]          rd_resp;
	logic [RES_W-1:0]    pick;

	// one conversion finishes on this cycle
	assign conv_done = (s_ff.fsm == AST_CONVERT) && s_ff.mode[MODE_START_BIT]
		&& s_ff.fad_tick && (s_ff.fad_cnt == CONV_FAD - 5'h01);
	assign wr_fire = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
	assign wr_lo = s_ff.wstrb[0];
	assign pick = s_ff.sync2[s_ff.cur_ch*RES_W +: RES_W];

	always_comb
	begin
		rd_val = '0;
		rd_resp = RESP_OKAY;
		unique case (s_axi_araddr)
			OFS_MODE:     rd_val[7:0] = s_ff.mode;
			OFS_CLK_GATE: rd_val[0] = s_ff.clk_gate;
			OFS_RESULT:   rd_val[15:0] = s_ff.result;
			OFS_IRQ_STAT: rd_val[IRQ_CONV_END_BIT] = s_ff.irq_stat;
			OFS_IRQ_MASK: rd_val[IRQ_CONV_END_BIT] = s_ff.irq_mask;
			OFS_PORT2:
			begin
				rd_val[PORT2_DIR_BIT] = s_ff.port_dir;
				rd_val[PORT2_OUT_BIT] = s_ff.port_out;
			end
			OFS_CHAN:     rd_val[CH_W-1:0] = s_ff.chan;
			OFS_STATUS:
			begin
				rd_val[0] = (s_ff.fsm == AST_CONVERT);
				rd_val[CH_W:1] = s_ff.last_ch;
			end
			default:      rd_resp = RESP_SLVERR;
		endcase
	end

	always_comb
	begin
		nxt_s = s_ff;
		// two-stage capture of the asynchronous analog sample words
		nxt_s.sync1 = {analog_input_ch3, analog_input_ch2,
			analog_input_ch1, analog_input_ch0};
		nxt_s.sync2 = s_ff.sync1;

		// write address and data taken in either order
		if (s_axi_awvalid && s_ff.awready)
		begin
			nxt_s.aw_have = 1'b1;
			nxt_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wready)
		begin
			nxt_s.w_have = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready)
			nxt_s.bvalid = 1'b0;

		if (wr_fire)
		begin
			nxt_s.aw_have = 1'b0;
			nxt_s.w_have = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			unique case (s_ff.awaddr)
				OFS_MODE:
					if (wr_lo)
						nxt_s.mode = s_ff.wdata[7:0];
				OFS_CLK_GATE:
					if (wr_lo)
						nxt_s.clk_gate = s_ff.wdata[0];
				OFS_RESULT:
					;
				OFS_IRQ_STAT:
					if (wr_lo && s_ff.wdata[IRQ_CONV_END_BIT])
						nxt_s.irq_stat = 1'b0;
				OFS_IRQ_MASK:
					if (wr_lo)
						nxt_s.irq_mask = s_ff.wdata[IRQ_CONV_END_BIT];
				OFS_PORT2:
					if (wr_lo)
					begin
						nxt_s.port_dir = s_ff.wdata[PORT2_DIR_BIT];
						nxt_s.port_out = s_ff.wdata[PORT2_OUT_BIT];
					end
				OFS_CHAN:
					if (wr_lo)
						nxt_s.chan = s_ff.wdata[CH_W-1:0];
				OFS_STATUS:
					;
				default:
					nxt_s.bresp = RESP_SLVERR;
			endcase
		end
		nxt_s.awready = !nxt_s.aw_have && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_have && !nxt_s.bvalid;

		// read channel: one outstanding read
		if (s_axi_arvalid && s_ff.arready)
		begin
			nxt_s.arready = 1'b0;
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = rd_val;
			nxt_s.rresp = rd_resp;
		end
		else if (s_ff.rvalid && s_axi_rready)
		begin
			nxt_s.rvalid = 1'b0;
			nxt_s.arready = 1'b1;
		end

		// conversion clock divider, halted while the gate is off
		nxt_s.fad_tick = 1'b0;
		if (!s_ff.clk_gate)
			nxt_s.div_cnt = '0;
		else if (s_ff.div_cnt == 6'h00)
		begin
			nxt_s.div_cnt = DIV_M1[s_ff.mode[MODE_FR_LSB +: MODE_FR_W]];
			nxt_s.fad_tick = 1'b1;
		end
		else
			nxt_s.div_cnt = s_ff.div_cnt - 6'h01;

		unique case (s_ff.fsm)
			AST_IDLE:
				// only the software start bit launches a conversion
				if (s_ff.mode[MODE_START_BIT] && s_ff.clk_gate)
				begin
					nxt_s.fsm = AST_CONVERT;
					nxt_s.fad_cnt = '0;
					nxt_s.cur_ch = s_ff.mode[MODE_CHSEL_BIT] ? CHAN_RST : s_ff.chan;
				end
			AST_CONVERT:
				if (!s_ff.mode[MODE_START_BIT])
					nxt_s.fsm = AST_IDLE;
				else if (s_ff.fad_tick)
				begin
					nxt_s.fad_cnt = s_ff.fad_cnt + 5'h01;
					// hold the input at the end of the sampling window
					if (s_ff.fad_cnt == SAMPLE_FAD - 5'h01)
						nxt_s.held = pick;
					if (conv_done)
					begin
						nxt_s.result = {s_ff.held, RESULT_PAD};
						nxt_s.last_ch = s_ff.cur_ch;
						nxt_s.fad_cnt = '0;
						if (s_ff.mode[MODE_CHSEL_BIT])
							nxt_s.cur_ch = s_ff.cur_ch + 2'h1;
						else
							nxt_s.cur_ch = s_ff.chan;
					end
				end
		endcase

		// completion event beats a same-cycle software clear
		if (conv_done)
			nxt_s.irq_stat = 1'b1;
		nxt_s.irq = nxt_s.irq_stat && nxt_s.irq_mask;

		if (!aresetn)
		begin
			nxt_s = '0;
			nxt_s.mode = MODE_RST;
			nxt_s.port_dir = PORT2_DIR_RST;
			nxt_s.chan = CHAN_RST;
			nxt_s.fsm = AST_IDLE;
			nxt_s.awready = 1'b1;
			nxt_s.wready = 1'b1;
			nxt_s.arready = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			nxt_s.rresp = RESP_OKAY;
		end
	end

	always_ff @(posedge aclk)
	begin
		s_ff <= nxt_s;
	end

	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign port2_bit0_out = s_ff.port_out;
	assign port2_bit0_oe_n = s_ff.port_dir;
	assign conversion_end_irq = s_ff.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence seq_launch;
		(s_ff.fsm == AST_IDLE) && s_ff.mode[MODE_START_BIT] && s_ff.clk_gate;
	endsequence

	sequence seq_finish;
		conv_done;
	endsequence

	sequence seq_keep_going;
		conv_done && !(wr_fire && s_ff.awaddr == OFS_MODE);
	endsequence

	a_start_launches: assert property (
		seq_launch |=> (s_ff.fsm == AST_CONVERT) && (s_ff.fad_cnt == 5'h00))
		else $error("start bit did not launch a conversion");

	a_result_then_irq: assert property (
		seq_finish |=> s_ff.irq_stat
			&& (s_ff.result[15:RESULT_LSB] == $past(s_ff.held))
			&& (s_ff.irq == s_ff.irq_mask))
		else $error("result or interrupt missing after conversion end");

	a_no_hw_trigger: assert property (
		(s_ff.fsm == AST_IDLE) && !s_ff.mode[MODE_START_BIT]
			|=> s_ff.fsm == AST_IDLE)
		else $error("conversion began without the start bit");

	a_select_one_chan: assert property (
		seq_finish ##0 !s_ff.mode[MODE_CHSEL_BIT]
			|=> (s_ff.cur_ch == $past(s_ff.chan)) && (s_ff.last_ch == $past(s_ff.cur_ch)))
		else $error("select mode left the chosen channel");

	a_seq_repeat: assert property (
		seq_keep_going |=> (s_ff.fsm == AST_CONVERT) && (s_ff.fad_cnt == 5'h00)
			##1 (s_ff.fsm == AST_CONVERT) || !s_ff.mode[MODE_START_BIT])
		else $error("sequential conversion did not restart");

	a_irq_follows: assert property (
		s_ff.irq_stat && s_ff.irq_mask && !wr_fire |=> s_ff.irq)
		else $error("unmasked conversion end did not raise the interrupt");

	a_ch0_sample: assert property (
		(s_ff.fsm == AST_CONVERT) && s_ff.mode[MODE_START_BIT] && s_ff.fad_tick
			&& (s_ff.fad_cnt == SAMPLE_FAD - 5'h01) && (s_ff.cur_ch == CHAN_RST)
			|=> s_ff.held == $past(s_ff.sync2[RES_W-1:0]))
		else $error("channel zero sample not captured");

	a_scan_advance: assert property (
		seq_finish ##0 s_ff.mode[MODE_CHSEL_BIT]
			|=> s_ff.cur_ch == $past(s_ff.cur_ch) + 2'h1)
		else $error("scan mode did not step to the next channel");

	a_gate_stops: assert property (
		!s_ff.clk_gate ##1 !s_ff.clk_gate |-> !s_ff.fad_tick)
		else $error("conversion clock ran with the gate off");

	a_left_aligned: assert property (
		s_ff.result[RESULT_LSB-1:0] == RESULT_PAD)
		else $error("result not left aligned");

	sequence seq_gate_off;
		!s_ff.clk_gate ##1 !s_ff.clk_gate;
	endsequence

	a_stop_aborts: assert property (
		(s_ff.fsm == AST_CONVERT) && !s_ff.mode[MODE_START_BIT]
			|=> (s_ff.fsm == AST_IDLE) && $stable(s_ff.result))
		else $error("cleared start bit did not abort the conversion");

	a_gate_freeze: assert property (
		seq_gate_off ##0 (s_ff.fsm == AST_CONVERT) && s_ff.mode[MODE_START_BIT]
			|=> $stable(s_ff.fad_cnt) && (s_ff.fsm == AST_CONVERT))
		else $error("conversion advanced with the gate off");

	a_result_stands: assert property (
		!conv_done |=> $stable(s_ff.result) && $stable(s_ff.last_ch))
		else $error("result changed without a finished conversion");

	a_flag_sticky: assert property (
		s_ff.irq_stat && !(wr_fire && (s_ff.awaddr == OFS_IRQ_STAT))
			|=> s_ff.irq_stat)
		else $error("conversion end flag dropped without a clear");

	a_clear_drops: assert property (
		!conv_done && wr_fire && wr_lo && (s_ff.awaddr == OFS_IRQ_STAT)
			&& s_ff.wdata[IRQ_CONV_END_BIT] |=> !s_ff.irq_stat && !s_ff.irq)
		else $error("write of one did not clear the conversion end flag");

	a_launch_select: assert property (
		seq_launch ##0 !s_ff.mode[MODE_CHSEL_BIT] |=> s_ff.cur_ch == $past(s_ff.chan))
		else $error("select mode launched on another channel");

	a_scan_wraps: assert property (
		seq_finish ##0 s_ff.mode[MODE_CHSEL_BIT] && (&s_ff.cur_ch)
			|=> s_ff.cur_ch == CHAN_RST)
		else $error("scan mode did not wrap to channel zero");

	a_hold_window: assert property (
		!((s_ff.fsm == AST_CONVERT) && s_ff.mode[MODE_START_BIT] && s_ff.fad_tick
			&& (s_ff.fad_cnt == SAMPLE_FAD - 5'h01)) |=> $stable(s_ff.held))
		else $error("held sample changed outside the sampling point");

endmodule

// [testbench/ast_src.sv]
`timescale 1ns/10ps
module ast_src
	import ast_pkg::*;
(
	input  wire logic [RES_W-1:0] base,
	output      logic [RES_W-1:0] level_ch0,
	output      logic [RES_W-1:0] level_ch1,
	output      logic [RES_W-1:0] level_ch2,
	output      logic [RES_W-1:0] level_ch3
);
	// each channel steps away from base so results tell channels apart
	assign level_ch0 = base;
	assign level_ch1 = base + 10'h0C3;
	assign level_ch2 = base + 10'h186;
	assign level_ch3 = base + 10'h249;
endmodule

// [testbench/adc_sw_trigger_sequential_ctrl_test.sv]
`timescale 1ns/10ps
module adc_sw_trigger_sequential_ctrl_test
	import ast_pkg::*;
;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, rd;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid, oe_n, p_out, irq;
	logic [1:0]        bresp, rresp, pch, rs_next;
	time               t0;
	logic [RES_W-1:0]  base = 10'h2A5, ch0, ch1, ch2, ch3;
	int                err_total = 0;
	int                checks_done = 0;

	always #2 aclk = ~aclk;

	ast_ctrl ast_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.analog_input_ch0(ch0), .analog_input_ch1(ch1), .analog_input_ch2(ch2),
		.analog_input_ch3(ch3), .port2_bit0_out(p_out), .port2_bit0_oe_n(oe_n),
		.conversion_end_irq(irq));

	ast_src ast_src_i (.base(base), .level_ch0(ch0), .level_ch1(ch1), .level_ch2(ch2),
		.level_ch3(ch3));

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic hang();
		err_total++;
		$display("wrong value at %0t: wait ran out", $time);
		print_verdict();
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 100);
		if (n >= 100)
			hang();
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 100);
		if (n >= 100)
			hang();
		d = rdata;
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// processor sleeps until the end interrupt wakes it
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 600)
		begin
			@(posedge aclk);
			n++;
		end
		if (n >= 600)
			hang();
	endtask

	task automatic cw();
		axw(OFS_IRQ_STAT, 32'h1);
		wirq();
	endtask

	function automatic logic [31:0] res(input logic [1:0] k);
		return {16'h0, base + 10'(k) * 10'h0C3, RESULT_PAD};
	endfunction

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk({30'h0, p_out, oe_n}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		axr(OFS_MODE, rd);
		chk(rd, 32'h0);
		axr(OFS_PORT2, rd);
		chk(rd, 32'h1);
		axr(8'h40, rd, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'h40, 32'hFF, RESP_SLVERR);
		axw(OFS_PORT2, 32'h2);
		chk({30'h0, p_out, oe_n}, 32'h2);
		axw(OFS_PORT2, 32'h1);
		chk({30'h0, p_out, oe_n}, 32'h1);
		$display("test reset and port done");
		axw(OFS_CLK_GATE, 32'h1);
		axw(OFS_IRQ_MASK, 32'h1);
		axw(OFS_MODE, 32'h38);
		repeat (200) @(posedge aclk);
		axr(OFS_IRQ_STAT, rd);
		chk(rd, 32'h0);
		axw(OFS_MODE, 32'hB8);
		wirq();
		axr(OFS_RESULT, rd);
		chk(rd, res(2'h0));
		chk(rd >> 6, {22'h0, ch0});
		axw(OFS_IRQ_STAT, 32'h1);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		base <= 10'h15A;
		cw();
		cw();
		axr(OFS_RESULT, rd);
		chk(rd, res(2'h0));
		$display("test select mode done");
		axw(OFS_CHAN, 32'h2);
		cw();
		cw();
		axr(OFS_STATUS, rd);
		chk({30'h0, rd[2:1]}, 32'h2);
		chk({31'h0, rd[0]}, 32'h1);
		axr(OFS_RESULT, rd);
		chk(rd, res(2'h2));
		// speed code 6: back-to-back results one full conversion apart
		axw(OFS_MODE, 32'hB0);
		cw();
		cw();
		t0 = $time;
		cw();
		chk(32'(($time - t0) / 4), 32'(CONV_FAD) * (32'(DIV_M1[6]) + 32'h1));
		axw(OFS_MODE, 32'hF8);
		cw();
		for (int i = 0; i < 5; i++)
		begin
			cw();
			axr(OFS_STATUS, rd);
			pch = rd[2:1];
			axr(OFS_RESULT, rd);
			chk(rd, res(pch));
			if (i > 0)
				chk({30'h0, pch}, {30'h0, rs_next});
			rs_next = pch + 2'h1;
		end
		$display("test channel modes done");
		axw(OFS_CLK_GATE, 32'h0);
		axw(OFS_IRQ_STAT, 32'h1);
		repeat (300) @(posedge aclk);
		axr(OFS_IRQ_STAT, rd);
		chk(rd, 32'h0);
		axw(OFS_CLK_GATE, 32'h1);
		wirq();
		axw(OFS_MODE, 32'h0);
		axw(OFS_IRQ_STAT, 32'h1);
		repeat (200) @(posedge aclk);
		axr(OFS_IRQ_STAT, rd);
		chk(rd, 32'h0);
		axr(OFS_STATUS, rd);
		chk({31'h0, rd[0]}, 32'h0);
		axw(OFS_IRQ_MASK, 32'h0);
		axw(OFS_MODE, 32'hB8);
		for (int i = 0; i < 60 && rd[0] !== 1'b1; i++)
			axr(OFS_IRQ_STAT, rd);
		chk(rd, 32'h1);
		chk({31'h0, irq}, 32'h0);
		axw(OFS_IRQ_MASK, 32'h1);
		@(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		$display("test gate and interrupt done");
		print_verdict();
	end

endmodule
